// *** rtl/dst_split_timer.sv ***
// Dual 8-bit split-mode timer with its APB register file.
//
// How it works
// - Command field always reads back as zero in set and clear registers.
// - Command 0 none, 1 reserved, 2 restart, 3 hard reset unless enabled.
// - Command acts only when target field is 3 (both); others select none.
// - Writing one to a command-set bit sets only that bit.
// - Writing one to a command-clear bit clears only that bit.
// - Low compare request n forwarded only when enable bit 4+n is one.
// - High underflow request forwarded only when enable bit 1 is one.
// - Low underflow request forwarded only when enable bit 0 is one.
// - Low compare flag n sets while the timers run and low counter equals compare n.
// - Flags never self-clear; writing one clears, writing zero keeps.
// - High underflow flag sets when high timer reaches bottom.
// - Low underflow flag sets when low timer reaches bottom.
// - Debug halt with run-in-debug zero stops both timers.
// - With run-in-debug one, timers keep running during debug halt.
// - Software write to a counter wins over count, clear or reload.
// - Low period register is the top of the low timer.
// - High period register is the top of the high timer.
// - Split-select bit makes two independent 8-bit timers run.
// - Timers tick at peripheral clock divided by 1..1024 per select code.
//
// Decided for this implementation: the APB interface to the registers.
module dst_split_timer #(
   parameter int unsigned N_CMP = 3
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register bus.
   input wire dst_pkg::dst_apb_req_t apb_i,
   output dst_pkg::dst_apb_rsp_t apb_o,
   // Debug halt from the processor.
   input wire logic debug_halt_i,
   // Interrupt requests.
   output logic low_underflow_irq_o,
   output logic high_underflow_irq_o,
   output logic [N_CMP-1:0] low_compare_irq_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler tap: a tick occurs when the masked prescaler bits are all zero.
   function automatic logic [9:0] div_mask(input logic [2:0] sel);
      logic [9:0] m;
      m = 10'h000;
      case (sel)
         3'h0: m = 10'h000;
         3'h1: m = 10'h001;
         3'h2: m = 10'h003;
         3'h3: m = 10'h007;
         3'h4: m = 10'h00F;
         3'h5: m = 10'h03F;
         3'h6: m = 10'h0FF;
         default: m = 10'h3FF;
      endcase
      return m;
   endfunction

   // One down-count step with reload from the period after zero.
   function automatic logic [7:0] count_step(input logic [7:0] cnt, input logic [7:0] per);
      return (cnt == 8'h00) ? per : cnt - 8'h01;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   logic [3:0] ctrl_a;
   logic split_select;
   logic [1:0] command_target_select;
   logic [7:0] interrupt_enable;
   logic [7:0] interrupt_flags;
   logic run_in_debug_halt;
   logic [7:0] low_counter;
   logic [7:0] high_counter;
   logic [7:0] low_period_value;
   logic [7:0] high_period_value;
   logic [7:0] low_compare [N_CMP];
   logic [9:0] prescale;
   logic [31:0] rdata;
   logic [31:0] prdata_q;
   logic rd_err;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   wire logic [5:0] idx = apb_i.paddr[dst_pkg::ADDR_W-1:2];
   wire logic aligned = (apb_i.paddr[1:0] == 2'h0);
   wire logic setup = apb_i.psel & ~apb_i.penable;
   wire logic access = apb_i.psel & apb_i.penable;
   wire logic wr = access & apb_i.pwrite & apb_i.pstrb[0];
   wire logic [7:0] wd = apb_i.pwdata[7:0];
   wire logic is_cmp0 = (idx == dst_pkg::IDX_LOW_CMP0);
   wire logic is_cmp1 = (idx == dst_pkg::IDX_LOW_CMP1);
   wire logic is_cmp2 = (idx == dst_pkg::IDX_LOW_CMP2);
   wire logic mapped = aligned && (idx == dst_pkg::IDX_CTRL_A || idx == dst_pkg::IDX_CTRL_D ||
      idx == dst_pkg::IDX_CMD_CLR || idx == dst_pkg::IDX_CMD_SET || idx == dst_pkg::IDX_INT_EN ||
      idx == dst_pkg::IDX_INT_FLAGS || idx == dst_pkg::IDX_DBG_CTRL || idx == dst_pkg::IDX_LOW_CNT ||
      idx == dst_pkg::IDX_HIGH_CNT || idx == dst_pkg::IDX_LOW_PER || idx == dst_pkg::IDX_HIGH_PER ||
      is_cmp0 || is_cmp1 || is_cmp2);
   wire logic wr_ok = wr & mapped;
   wire logic wr_ctrl_a = wr_ok && idx == dst_pkg::IDX_CTRL_A;
   wire logic wr_ctrl_d = wr_ok && idx == dst_pkg::IDX_CTRL_D;
   wire logic wr_set = wr_ok && idx == dst_pkg::IDX_CMD_SET;
   wire logic wr_clr = wr_ok && idx == dst_pkg::IDX_CMD_CLR;
   wire logic wr_int_en = wr_ok && idx == dst_pkg::IDX_INT_EN;
   wire logic wr_flags = wr_ok && idx == dst_pkg::IDX_INT_FLAGS;
   wire logic wr_dbg = wr_ok && idx == dst_pkg::IDX_DBG_CTRL;
   wire logic wr_low_count = wr_ok && idx == dst_pkg::IDX_LOW_CNT;
   wire logic wr_high_count = wr_ok && idx == dst_pkg::IDX_HIGH_CNT;
   wire logic wr_low_period = wr_ok && idx == dst_pkg::IDX_LOW_PER;
   wire logic wr_high_period = wr_ok && idx == dst_pkg::IDX_HIGH_PER;
   wire logic [N_CMP-1:0] wr_cmp = {N_CMP{wr_ok}} & {is_cmp2, is_cmp1, is_cmp0};

   ////////////////////////////////////////////////////////////////////////////////
   // Command handling.
   wire logic enabled = ctrl_a[dst_pkg::CTRL_A_EN_BIT];
   wire logic [1:0] wr_cmd = wd[dst_pkg::CMD_LSB +: 2];
   wire logic [1:0] wr_tgt = wd[dst_pkg::TGT_LSB +: 2];
   wire logic [1:0] next_target = wr_set ? (command_target_select | wr_tgt) :
      wr_clr ? (command_target_select & ~wr_tgt) : command_target_select;
   wire logic cmd_both = (next_target == dst_pkg::TGT_BOTH);
   wire logic do_restart = wr_set && wr_cmd == dst_pkg::CMD_RESTART && cmd_both;
   wire logic do_hard = wr_set && wr_cmd == dst_pkg::CMD_HARD_RESET && cmd_both
      && !enabled;

   ////////////////////////////////////////////////////////////////////////////////
   // Tick generation and counting.
   wire logic running = enabled & split_select
      & (~debug_halt_i | run_in_debug_halt);
   wire logic tick = running &&
      ((prescale & div_mask(ctrl_a[dst_pkg::CTRL_A_SEL_LSB +: 3])) == 10'h000);
   wire logic low_bottom = tick && low_counter == 8'h00;
   wire logic high_bottom = tick && high_counter == 8'h00;
   wire logic [7:0] low_step = count_step(low_counter, low_period_value);
   wire logic [7:0] high_step = count_step(high_counter, high_period_value);

   logic [N_CMP-1:0] cmp_hit;
   always_comb begin
      for (int i = 0; i < N_CMP; i++) begin
         cmp_hit[i] = running && (low_counter == low_compare[i]);
      end
   end

   logic [7:0] flag_set;
   always_comb begin
      flag_set = 8'h00;
      flag_set[dst_pkg::INT_LOW_UNDERFLOW_BIT] = low_bottom;
      flag_set[dst_pkg::INT_HIGH_UNDERFLOW_BIT] = high_bottom;
      flag_set[dst_pkg::INT_LCMP_LSB +: N_CMP] = cmp_hit;
   end

   // A flag set in the same cycle as its clear stays set.
   wire logic [7:0] next_flags = (interrupt_flags & ~(wr_flags ? wd : 8'h00)
      | flag_set) & dst_pkg::INT_MASK;

   ////////////////////////////////////////////////////////////////////////////////
   // Read data.
   always_comb begin
      rdata = 32'h0000_0000;
      if (idx == dst_pkg::IDX_CTRL_A) begin
         rdata[3:0] = ctrl_a;
      end else if (idx == dst_pkg::IDX_CTRL_D) begin
         rdata[dst_pkg::SPLIT_BIT] = split_select;
      end else if (idx == dst_pkg::IDX_CMD_CLR || idx == dst_pkg::IDX_CMD_SET) begin
         rdata[dst_pkg::TGT_LSB +: 2] = command_target_select;
      end else if (idx == dst_pkg::IDX_INT_EN) begin
         rdata[7:0] = interrupt_enable;
      end else if (idx == dst_pkg::IDX_INT_FLAGS) begin
         rdata[7:0] = interrupt_flags;
      end else if (idx == dst_pkg::IDX_DBG_CTRL) begin
         rdata[dst_pkg::DBG_RUN_BIT] = run_in_debug_halt;
      end else if (idx == dst_pkg::IDX_LOW_CNT) begin
         rdata[7:0] = low_counter;
      end else if (idx == dst_pkg::IDX_HIGH_CNT) begin
         rdata[7:0] = high_counter;
      end else if (idx == dst_pkg::IDX_LOW_PER) begin
         rdata[7:0] = low_period_value;
      end else if (idx == dst_pkg::IDX_HIGH_PER) begin
         rdata[7:0] = high_period_value;
      end else if (is_cmp0) begin
         rdata[7:0] = low_compare[0];
      end else if (is_cmp1) begin
         rdata[7:0] = low_compare[1];
      end else if (is_cmp2) begin
         rdata[7:0] = low_compare[2];
      end else begin
         rdata = 32'h0000_0000;
      end
   end

   // Read data is captured in the setup cycle and stands through the access phase.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         prdata_q <= 32'h0000_0000;
         rd_err <= 1'b0;
      end else if (setup) begin
         prdata_q <= aligned ? rdata : 32'h0000_0000;
         rd_err <= ~mapped;
      end
   end

   // The whole response struct has a single driver; the slave never inserts wait states.
   assign apb_o = '{pready: 1'b1, pslverr: access & rd_err, prdata: prdata_q};

   ////////////////////////////////////////////////////////////////////////////////
   // Control registers that a hard reset leaves alone.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ctrl_a <= 4'h0;
         split_select <= 1'b0;
         run_in_debug_halt <= 1'b0;
         prescale <= 10'h000;
      end else begin
         if (wr_ctrl_a) begin
            ctrl_a <= wd[3:0];
         end
         if (wr_ctrl_d) begin
            split_select <= wd[dst_pkg::SPLIT_BIT];
         end
         if (wr_dbg) begin
            run_in_debug_halt <= wd[dst_pkg::DBG_RUN_BIT];
         end
         prescale <= running ? prescale + 10'h001 : 10'h000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Split-mode registers.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || do_hard) begin
         command_target_select <= 2'h0;
         interrupt_enable <= dst_pkg::REG_RESET;
         interrupt_flags <= dst_pkg::REG_RESET;
         low_period_value <= dst_pkg::REG_RESET;
         high_period_value <= dst_pkg::REG_RESET;
         for (int i = 0; i < N_CMP; i++) begin
            low_compare[i] <= dst_pkg::REG_RESET;
         end
      end else begin
         command_target_select <= next_target;
         interrupt_flags <= next_flags;
         if (wr_int_en) begin
            interrupt_enable <= wd & dst_pkg::INT_MASK;
         end
         if (wr_low_period) begin
            low_period_value <= wd;
         end
         if (wr_high_period) begin
            high_period_value <= wd;
         end
         for (int i = 0; i < N_CMP; i++) begin
            if (wr_cmp[i]) begin
               low_compare[i] <= wd;
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || do_hard) begin
         low_counter <= dst_pkg::REG_RESET;
      end else if (wr_low_count) begin
         low_counter <= wd;
      end else if (do_restart) begin
         low_counter <= low_period_value;
      end else if (tick) begin
         low_counter <= low_step;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i || do_hard) begin
         high_counter <= dst_pkg::REG_RESET;
      end else if (wr_high_count) begin
         high_counter <= wd;
      end else if (do_restart) begin
         high_counter <= high_period_value;
      end else if (tick) begin
         high_counter <= high_step;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt requests.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         low_underflow_irq_o <= 1'b0;
         high_underflow_irq_o <= 1'b0;
         low_compare_irq_o <= '0;
      end else begin
         low_underflow_irq_o <= interrupt_flags[dst_pkg::INT_LOW_UNDERFLOW_BIT]
            & interrupt_enable[dst_pkg::INT_LOW_UNDERFLOW_BIT];
         high_underflow_irq_o <= interrupt_flags[dst_pkg::INT_HIGH_UNDERFLOW_BIT]
            & interrupt_enable[dst_pkg::INT_HIGH_UNDERFLOW_BIT];
         low_compare_irq_o <= interrupt_flags[dst_pkg::INT_LCMP_LSB +: N_CMP]
            & interrupt_enable[dst_pkg::INT_LCMP_LSB +: N_CMP];
      end
   end

endmodule

// *** rtl/dst_pkg.sv ***
// Package with register map, field layout and bus types of the dual split timer.
package dst_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   localparam int unsigned ADDR_W = 8;
   localparam logic [5:0] IDX_CTRL_A = 6'h00;
   localparam logic [5:0] IDX_CTRL_D = 6'h03;
   localparam logic [5:0] IDX_CMD_CLR = 6'h04;
   localparam logic [5:0] IDX_CMD_SET = 6'h05;
   localparam logic [5:0] IDX_INT_EN = 6'h0A;
   localparam logic [5:0] IDX_INT_FLAGS = 6'h0B;
   localparam logic [5:0] IDX_DBG_CTRL = 6'h0E;
   localparam logic [5:0] IDX_LOW_CNT = 6'h20;
   localparam logic [5:0] IDX_HIGH_CNT = 6'h21;
   localparam logic [5:0] IDX_LOW_PER = 6'h26;
   localparam logic [5:0] IDX_HIGH_PER = 6'h27;
   localparam logic [5:0] IDX_LOW_CMP0 = 6'h28;
   localparam logic [5:0] IDX_LOW_CMP1 = 6'h2A;
   localparam logic [5:0] IDX_LOW_CMP2 = 6'h2C;

   ////////////////////////////////////////////////////////////////////////////////
   localparam int unsigned CTRL_A_EN_BIT = 0;
   localparam int unsigned CTRL_A_SEL_LSB = 1;
   localparam int unsigned SPLIT_BIT = 0;
   localparam int unsigned DBG_RUN_BIT = 0;
   localparam int unsigned CMD_LSB = 2;
   localparam int unsigned TGT_LSB = 0;
   localparam int unsigned INT_LOW_UNDERFLOW_BIT = 0;
   localparam int unsigned INT_HIGH_UNDERFLOW_BIT = 1;
   localparam int unsigned INT_LCMP_LSB = 4;
   localparam logic [7:0] INT_MASK = 8'h73;
   localparam logic [7:0] CTRL_A_MASK = 8'h0F;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] CMD_NONE = 2'h0;
   localparam logic [1:0] CMD_RESTART = 2'h2;
   localparam logic [1:0] CMD_HARD_RESET = 2'h3;
   localparam logic [1:0] TGT_BOTH = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
      logic [3:0] pstrb;
   } dst_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } dst_apb_rsp_t;

endpackage

// *** dv/dst_split_timer_monitor.sv ***
// Port checker of the dual split timer, bound to its top module.
module dst_split_timer_monitor #(
   parameter int unsigned N_CMP = 3
) (
   // Clock and reset.
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register bus.
   input wire dst_pkg::dst_apb_req_t apb_i,
   input wire dst_pkg::dst_apb_rsp_t apb_o,
   // Debug halt and interrupts.
   input wire logic debug_halt_i,
   input wire logic low_underflow_irq_o,
   input wire logic high_underflow_irq_o,
   input wire logic [N_CMP-1:0] low_compare_irq_o
);
   ////////////////////////////////////////////////////////////////////////////////
   logic [7:0] en_seen;
   logic run_seen;
   wire logic wr = apb_i.psel && apb_i.penable && apb_i.pwrite;
   wire logic [5:0] idx = apb_i.paddr[7:2];
   wire logic [N_CMP+1:0] irq = {low_compare_irq_o, high_underflow_irq_o, low_underflow_irq_o};
   wire logic en_wr = wr && idx == dst_pkg::IDX_INT_EN;
   wire logic clr_wr = en_wr || (wr && (idx == dst_pkg::IDX_INT_FLAGS || idx == dst_pkg::IDX_CMD_SET));
   wire logic cmd_idx = idx == dst_pkg::IDX_CMD_SET || idx == dst_pkg::IDX_CMD_CLR;
   wire logic bad_idx = (idx >= 6'h06 && idx <= 6'h09) || apb_i.paddr[1:0] != 2'h0;
   wire logic run_ok = !debug_halt_i || run_seen;

   // Shadows the enables and run-in-debug bit as software last wrote them.
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         en_seen <= 8'h00;
         run_seen <= 1'b0;
      end else begin
         if (en_wr) begin
            en_seen <= apb_i.pwdata[7:0];
         end
         if (wr && idx == dst_pkg::IDX_DBG_CTRL) begin
            run_seen <= apb_i.pwdata[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_setup;
      apb_i.psel && !apb_i.penable;
   endsequence
   sequence s_read;
      apb_i.psel && apb_i.penable && !apb_i.pwrite;
   endsequence

   a_ready_high: assert property (apb_o.pready) else $error("pready low");
   a_upper_zero: assert property (s_read |-> apb_o.prdata[31:8] == 24'h000000) else $error("upper read bits set");
   a_cmd_zero: assert property ((s_read ##0 cmd_idx) |-> apb_o.prdata[3:2] == 2'h0)
      else $error("command field read nonzero");
   a_err_unmapped: assert property (s_setup ##1 (apb_i.penable && bad_idx) |-> apb_o.pslverr)
      else $error("no error on unmapped access");
   a_err_timing: assert property (apb_o.pslverr |-> apb_i.psel && apb_i.penable) else $error("stray pslverr");
   a_low_unf_mask: assert property (low_underflow_irq_o |-> $past(en_seen[0]))
      else $error("low underflow irq while masked");
   a_high_unf_mask: assert property (high_underflow_irq_o |-> $past(en_seen[1]))
      else $error("high underflow irq while masked");
   a_cmp_mask: assert property ((low_compare_irq_o & ~$past(en_seen[4 +: N_CMP])) == '0)
      else $error("compare irq while masked");
   a_flags_sticky: assert property (|($past(irq) & ~irq) |-> $past(clr_wr, 2))
      else $error("irq dropped without software clear");
   a_halt_freeze: assert property (|(irq & ~$past(irq)) |-> $past(run_ok, 2) || $past(en_wr, 2))
      else $error("irq raised while halted");
endmodule

bind dst_split_timer dst_split_timer_monitor #(.N_CMP(N_CMP)) u_monitor (
   .ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i),
   .apb_i(apb_i),
   .apb_o(apb_o),
   .debug_halt_i(debug_halt_i),
   .low_underflow_irq_o(low_underflow_irq_o),
   .high_underflow_irq_o(high_underflow_irq_o),
   .low_compare_irq_o(low_compare_irq_o)
);

// *** dv/tb_dst_split_timer.sv ***
// Self-checking bench of the dual split timer.
module tb_dst_split_timer;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic debug_halt_i = 1'b0;
   dst_pkg::dst_apb_req_t apb_i = '0;
   dst_pkg::dst_apb_rsp_t apb_o;
   logic low_underflow_irq_o;
   logic high_underflow_irq_o;
   logic [2:0] low_compare_irq_o;
   logic [7:0] exp_q[$];
   int miscompares = 0;
   int checked = 0;
   int seed = 94480;
   int div[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

   always #4 ref_clk_i = ~ref_clk_i;

   dst_split_timer #(.N_CMP(3)) u_dut (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .apb_i(apb_i),
      .apb_o(apb_o),
      .debug_halt_i(debug_halt_i),
      .low_underflow_irq_o(low_underflow_irq_o),
      .high_underflow_irq_o(high_underflow_irq_o),
      .low_compare_irq_o(low_compare_irq_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (miscompares == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] e);
      checked++;
      if (got !== e) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, e);
      end
   endtask

   // One APB transfer; a read notes its expected byte for the watcher.
   task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [7:0] e);
      int n = 0;
      if (!w) begin
         exp_q.push_back(e);
      end
      apb_i.psel <= 1'b1;
      apb_i.penable <= 1'b0;
      apb_i.pwrite <= w;
      apb_i.paddr <= {idx, 2'h0};
      apb_i.pwdata <= {24'h000000, d};
      apb_i.pstrb <= 4'hF;
      @(posedge ref_clk_i);
      apb_i.penable <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (apb_o.pready !== 1'b1 && n < 20);
      if (apb_o.pready !== 1'b1) begin
         miscompares++;
         end_sim();
      end
      apb_i.psel <= 1'b0;
      apb_i.penable <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d, 8'h00);
   endtask

   task automatic rd(input logic [5:0] idx, input logic [7:0] e);
      xfer(1'b0, idx, 8'h00, e);
   endtask

   task automatic chk_irq(input logic [4:0] e);
      @(posedge ref_clk_i);
      #1;
      cmp8({3'h0, low_compare_irq_o, high_underflow_irq_o, low_underflow_irq_o}, {3'h0, e});
   endtask

   // Watches read completions and compares them with the oldest note.
   always @(posedge ref_clk_i) begin
      if (apb_i.psel && apb_i.penable && !apb_i.pwrite && apb_o.pready === 1'b1 && exp_q.size() > 0) begin
         cmp8(apb_o.prdata[7:0], exp_q.pop_front());
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [5:0] regs[9] = '{dst_pkg::IDX_CMD_CLR, dst_pkg::IDX_CMD_SET, dst_pkg::IDX_INT_EN,
         dst_pkg::IDX_INT_FLAGS, dst_pkg::IDX_DBG_CTRL, dst_pkg::IDX_LOW_CNT, dst_pkg::IDX_HIGH_CNT,
         dst_pkg::IDX_LOW_PER, dst_pkg::IDX_HIGH_PER};
      logic [7:0] v;
      repeat (5) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      foreach (regs[i]) rd(regs[i], 8'h00);
      rd(6'h07, 8'h00);
      for (int i = 5; i < 9; i++) begin
         v = 8'($random(seed));
         wr(regs[i], v);
         rd(regs[i], v);
      end
      v = 8'($random(seed));
      wr(dst_pkg::IDX_INT_EN, v);
      rd(dst_pkg::IDX_INT_EN, v & dst_pkg::INT_MASK);
      wr(dst_pkg::IDX_CMD_SET, 8'h01);
      rd(dst_pkg::IDX_CMD_SET, 8'h01);
      wr(dst_pkg::IDX_CMD_SET, 8'h02);
      rd(dst_pkg::IDX_CMD_CLR, 8'h03);
      wr(dst_pkg::IDX_CMD_CLR, 8'h01);
      rd(dst_pkg::IDX_CMD_SET, 8'h02);
      wr(dst_pkg::IDX_LOW_PER, 8'h20);
      wr(dst_pkg::IDX_LOW_CNT, 8'h05);
      wr(dst_pkg::IDX_CMD_SET, 8'h03);
      wr(dst_pkg::IDX_CMD_SET, 8'h07);
      rd(dst_pkg::IDX_LOW_CNT, 8'h05);
      wr(dst_pkg::IDX_CMD_SET, 8'h0B);
      rd(dst_pkg::IDX_LOW_CNT, 8'h20);
      wr(dst_pkg::IDX_CMD_CLR, 8'h03);
      wr(dst_pkg::IDX_LOW_CNT, 8'h05);
      wr(dst_pkg::IDX_CMD_SET, 8'h09);
      rd(dst_pkg::IDX_LOW_CNT, 8'h05);
      wr(dst_pkg::IDX_CMD_SET, 8'h0C);
      rd(dst_pkg::IDX_LOW_PER, 8'h20);
      wr(dst_pkg::IDX_CMD_SET, 8'h0E);
      foreach (regs[i]) rd(regs[i], 8'h00);
      wr(dst_pkg::IDX_LOW_PER, 8'h05);
      wr(dst_pkg::IDX_LOW_CMP0, 8'h03);
      wr(dst_pkg::IDX_LOW_CMP1, 8'hF0);
      wr(dst_pkg::IDX_INT_EN, 8'h11);
      wr(dst_pkg::IDX_LOW_CNT, 8'h02);
      wr(dst_pkg::IDX_CTRL_A, 8'h01);
      rd(dst_pkg::IDX_LOW_CNT, 8'h02);
      wr(dst_pkg::IDX_CMD_SET, 8'h0F);
      rd(dst_pkg::IDX_LOW_PER, 8'h05);
      wr(dst_pkg::IDX_CTRL_D, 8'h01);
      repeat (20) @(posedge ref_clk_i);
      wr(dst_pkg::IDX_CTRL_A, 8'h00);
      rd(dst_pkg::IDX_INT_FLAGS, 8'h53);
      chk_irq(5'b00101);
      wr(dst_pkg::IDX_INT_FLAGS, 8'h01);
      rd(dst_pkg::IDX_INT_FLAGS, 8'h52);
      chk_irq(5'b00100);
      wr(dst_pkg::IDX_INT_EN, 8'h02);
      chk_irq(5'b00010);
      wr(dst_pkg::IDX_CTRL_A, 8'h01);
      debug_halt_i <= 1'b1;
      wr(dst_pkg::IDX_LOW_CNT, 8'h80);
      repeat (8) @(posedge ref_clk_i);
      rd(dst_pkg::IDX_LOW_CNT, 8'h80);
      wr(dst_pkg::IDX_DBG_CTRL, 8'h01);
      rd(dst_pkg::IDX_LOW_CNT, 8'h7F);
      debug_halt_i <= 1'b0;
      wr(dst_pkg::IDX_LOW_CNT, 8'h40);
      rd(dst_pkg::IDX_LOW_CNT, 8'h3F);
      wr(dst_pkg::IDX_LOW_PER, 8'hFF);
      wr(dst_pkg::IDX_HIGH_PER, 8'hFF);
      for (int k = 0; k < 8; k++) begin
         wr(dst_pkg::IDX_CTRL_A, 8'h00);
         wr(dst_pkg::IDX_LOW_CNT, 8'hFF);
         wr(dst_pkg::IDX_HIGH_CNT, 8'hFF);
         wr(dst_pkg::IDX_CTRL_A, {4'h0, 3'(k), 1'b1});
         repeat (2046) @(posedge ref_clk_i);
         wr(dst_pkg::IDX_CTRL_A, 8'h00);
         rd(dst_pkg::IDX_LOW_CNT, 8'hFF - 8'(2048 / div[k] + 1));
         rd(dst_pkg::IDX_HIGH_CNT, 8'hFF - 8'(2048 / div[k] + 1));
      end
      end_sim();
   end
endmodule
